// file: logic/tmr_timer16.sv
// 16-bit timer with prescaler, special event reset and apb registers
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_timer16
   import tmr_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         ext_clk_pin,
   input  wire logic         cmp_trigger,
   input  wire logic         sleep_exec,
   input  wire logic         wake_event,
   input  wire logic         osc_fail,
   output logic              irq,
   output logic              osc_run_enable,
   output logic              osc_low_power,
   output logic              sys_clk_from_osc,
   output logic [1:0]        power_state
);
   tmr_apb_req_t req;
   tmr_apb_rsp_t rsp;
   assign req = '{psel, penable, pwrite, paddr, pwdata};

   logic [7:0]  ctrl_reg;
   logic [15:0] cnt_reg, cnt_next;
   logic [7:0]  hbuf_reg;
   logic [2:0]  ps_reg, ps_next;
   logic [1:0]  idiv_reg;
   logic        flag_reg;
   logic        ien_reg;
   logic [1:0]  scs_reg;
   logic        idle_on_sleep_enable_reg;
   logic        lpcfg_reg;
   logic [3:0]  mode_reg;
   logic        fail_reg;
   tmr_pwr_t    pwr_reg, pwr_next;

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction

   // apb decode
   wire acc      = req.psel & req.penable;
   wire wr       = acc & req.pwrite;
   wire rd       = acc & ~req.pwrite;
   wire sel_ctrl = hit(req.paddr, `TMR_OFF_CTRL);
   wire sel_cntl = hit(req.paddr, `TMR_OFF_CNTL);
   wire sel_cnth = hit(req.paddr, `TMR_OFF_CNTH);
   wire sel_flag = hit(req.paddr, `TMR_OFF_FLAG);
   wire sel_ien  = hit(req.paddr, `TMR_OFF_IEN);
   wire sel_osc  = hit(req.paddr, `TMR_OFF_OSC);
   wire sel_cfg  = hit(req.paddr, `TMR_OFF_CFG);
   wire sel_cmp  = hit(req.paddr, `TMR_OFF_CMP);
   wire sel_md   = hit(req.paddr, `TMR_OFF_CMPMD);
   wire mapped   = sel_ctrl | sel_cntl | sel_cnth | sel_flag | sel_ien
                 | sel_osc | sel_cfg | sel_cmp | sel_md;
   wire wr_ctrl  = wr & sel_ctrl;
   wire wr_cntl  = wr & sel_cntl;
   wire wr_cnth  = wr & sel_cnth;
   wire rd_cntl  = rd & sel_cntl;

   // control fields
   wire wide     = ctrl_reg[`TMR_B_WIDE];
   wire cnt_on   = ctrl_reg[`TMR_B_ON];
   wire ext_cs   = ctrl_reg[`TMR_B_EXTCS];
   wire no_sync  = ctrl_reg[`TMR_B_NOSYNC];
   wire [1:0] ps_sel = ctrl_reg[`TMR_B_PS_HI:`TMR_B_PS_LO];

   // external clock or oscillator output, synchronised
   logic ext_level, ext_rise;
   tmr_pin_sync u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .pin   (ext_clk_pin),
      .level (ext_level),
      .rise  (ext_rise)
   );

   // instruction-cycle enable, one in four clocks
   wire instr_tick = (idiv_reg == `TMR_INSTR_DIV);
   wire src_tick   = ext_cs ? ext_rise : instr_tick;

   // prescaler: terminal count per select code
   wire [2:0] ps_term = 3'((4'h1 << ps_sel) - 4'h1);
   wire ps_done  = (ps_reg == ps_term);
   wire cnt_tick = cnt_on & src_tick & ps_done;
   wire overflow = cnt_tick & (cnt_reg == `TMR_CNT_MAX);

   // trigger honoured only when unsynchronised external mode is off
   wire sync_mode = ~ext_cs | ~no_sync;
   wire spev = cmp_trigger & (mode_reg == `TMR_MODE_SPEV) & sync_mode;

   always_comb begin
      ps_next = ps_reg;
      if (cnt_on & src_tick) begin
         ps_next = ps_done ? `TMR_PS_RST : 3'(ps_reg + `TMR_ONE3);
      end
      if (wr_cntl) begin
         ps_next = `TMR_PS_RST;
      end
   end

   // write priority over trigger, trigger over counting
   always_comb begin
      cnt_next = cnt_reg;
      if (cnt_tick) begin
         cnt_next = 16'(cnt_reg + `TMR_ONE16);
      end
      if (spev) begin
         cnt_next = `TMR_CNT_ZERO;
      end
      if (wr_cntl) begin
         cnt_next = {wide ? hbuf_reg : cnt_reg[15:8], pwdata[7:0]};
      end else if (wr_cnth & ~wide) begin
         cnt_next = {pwdata[7:0], cnt_reg[7:0]};
      end
   end

   // power-managed mode sequencing
   wire sec_sel = (scs_reg == `TMR_SCS_SEC) & ctrl_reg[`TMR_B_OSCEN];
   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         TMR_PWR_RUN: begin
            if (sec_sel & ~fail_reg) begin
               pwr_next = TMR_PWR_SEC_RUN;
            end else if (sleep_exec) begin
               pwr_next = idle_on_sleep_enable_reg ? TMR_PWR_SLEEP : TMR_PWR_RUN;
            end
         end
         TMR_PWR_SEC_RUN: begin
            if (fail_reg | ~sec_sel) begin
               pwr_next = TMR_PWR_RUN;
            end else if (sleep_exec) begin
               pwr_next = idle_on_sleep_enable_reg ? TMR_PWR_SLEEP : TMR_PWR_SEC_IDLE;
            end
         end
         TMR_PWR_SEC_IDLE: begin
            if (fail_reg) begin
               pwr_next = TMR_PWR_RUN;
            end else if (wake_event) begin
               pwr_next = TMR_PWR_SEC_RUN;
            end
         end
         TMR_PWR_SLEEP: begin
            if (wake_event) begin
               pwr_next = TMR_PWR_RUN;
            end
         end
      endcase
   end

   wire osc_clocks = (pwr_reg == TMR_PWR_SEC_RUN)
                   | (pwr_reg == TMR_PWR_SEC_IDLE);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_reg <= `TMR_CTRL_RST;
         cnt_reg  <= `TMR_CNT_ZERO;
         hbuf_reg <= 8'h00;
         ps_reg   <= `TMR_PS_RST;
         idiv_reg <= 2'h0;
         pwr_reg  <= TMR_PWR_RUN;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= pwdata[7:0];
         end
         cnt_reg  <= cnt_next;
         ps_reg   <= ps_next;
         idiv_reg <= 2'(idiv_reg + 2'h1);
         pwr_reg  <= pwr_next;
         if (rd_cntl & wide) begin
            hbuf_reg <= cnt_reg[15:8];
         end else if (wr_cnth & wide) begin
            hbuf_reg <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         flag_reg  <= 1'b0;
         ien_reg   <= 1'b0;
         scs_reg   <= 2'h0;
         idle_on_sleep_enable_reg <= 1'b0;
         lpcfg_reg <= 1'b0;
         mode_reg  <= 4'h0;
         fail_reg  <= 1'b0;
      end else begin
         // set wins over write-one-to-clear; trigger never sets
         if (overflow) begin
            flag_reg <= 1'b1;
         end else if (wr & sel_flag & pwdata[`TMR_B_OVF]) begin
            flag_reg <= 1'b0;
         end
         if (wr & sel_ien) begin
            ien_reg <= pwdata[`TMR_B_OVF];
         end
         if (wr & sel_osc) begin
            scs_reg   <= pwdata[1:0];
            idle_on_sleep_enable_reg <= pwdata[`TMR_B_IDLE_ON_SLEEP_ENABLE];
         end
         if (wr & sel_cfg) begin
            lpcfg_reg <= pwdata[0];
         end
         if (wr & sel_md) begin
            mode_reg <= pwdata[3:0];
         end
         // fail-safe switchover latched until source reselected
         if (osc_fail & osc_clocks) begin
            fail_reg <= 1'b1;
         end else if (wr & sel_osc) begin
            fail_reg <= 1'b0;
         end
      end
   end

   // read mux
   wire [7:0] ctrl_rd = {ctrl_reg[7], osc_clocks, ctrl_reg[5:0]};
   wire [7:0] cnth_rd = wide ? hbuf_reg : cnt_reg[15:8];
   always_comb begin
      rsp.prdata  = 32'h0000_0000;
      rsp.pready  = 1'b1;
      rsp.pslverr = acc & ~mapped;
      if (sel_ctrl) rsp.prdata[7:0] = ctrl_rd;
      if (sel_cntl) rsp.prdata[7:0] = cnt_reg[7:0];
      if (sel_cnth) rsp.prdata[7:0] = cnth_rd;
      if (sel_flag) rsp.prdata[0]   = flag_reg;
      if (sel_ien)  rsp.prdata[0]   = ien_reg;
      if (sel_osc)  rsp.prdata[7:0] = {idle_on_sleep_enable_reg, 5'h00, scs_reg};
      if (sel_cfg)  rsp.prdata[0]   = lpcfg_reg;
      if (sel_md)   rsp.prdata[3:0] = mode_reg;
   end
   assign prdata  = rsp.prdata;
   assign pready  = rsp.pready;
   assign pslverr = rsp.pslverr;

   assign irq              = flag_reg & ien_reg;
   assign osc_run_enable   = ctrl_reg[`TMR_B_OSCEN];
   assign osc_low_power    = lpcfg_reg;
   assign sys_clk_from_osc = osc_clocks;
   assign power_state      = pwr_reg;
endmodule

// file: logic/tmr_consts.svh
// offsets, field positions and reset values for the timer block
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_OFF_CTRL     12'h000
`define TMR_OFF_CNTL     12'h004
`define TMR_OFF_CNTH     12'h008
`define TMR_OFF_FLAG     12'h00C
`define TMR_OFF_IEN      12'h010
`define TMR_OFF_OSC      12'h014
`define TMR_OFF_CFG      12'h018
`define TMR_OFF_CMP      12'h01C
`define TMR_OFF_CMPMD    12'h020
`define TMR_B_ON         0
`define TMR_B_EXTCS      1
`define TMR_B_NOSYNC     2
`define TMR_B_OSCEN      3
`define TMR_B_PS_LO      4
`define TMR_B_PS_HI      5
`define TMR_B_RUN        6
`define TMR_B_WIDE       7
`define TMR_B_OVF        0
`define TMR_B_IDLE_ON_SLEEP_ENABLE      7
`define TMR_SCS_SEC      2'h1
`define TMR_MODE_SPEV    4'hB
`define TMR_CNT_ZERO     16'h0000
`define TMR_CNT_MAX      16'hFFFF
`define TMR_CTRL_RST     8'h00
`define TMR_PS_RST       3'h0
`define TMR_INSTR_DIV    2'h3
`define TMR_ONE3         3'h1
`define TMR_ONE16        16'h0001
`endif

// file: logic/tmr_pkg.sv
// types shared by the timer block
package tmr_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tmr_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tmr_apb_rsp_t;
   typedef enum logic [1:0] {
      TMR_PWR_RUN,
      TMR_PWR_SEC_RUN,
      TMR_PWR_SEC_IDLE,
      TMR_PWR_SLEEP
   } tmr_pwr_t;
endpackage

// file: logic/tmr_pin_sync.sv
// three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
module tmr_pin_sync
   import tmr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);
   logic [2:0] sh_reg;
   logic       level_reg;
   logic       agree;
   // a change counts once stages two and three agree
   assign agree = (sh_reg[1] == sh_reg[2]);
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sh_reg    <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         sh_reg <= {sh_reg[1:0], pin};
         if (agree) begin
            level_reg <= sh_reg[2];
         end
      end
   end
   assign level = level_reg;
   assign rise  = agree & sh_reg[2] & ~level_reg;
endmodule

// file: tb/tmr_chk.sv
// concurrent checks on the timer ports
`timescale 1ns/1ps
module tmr_chk
   import tmr_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        sleep_exec,
   input wire logic        osc_fail,
   input wire logic        irq,
   input wire logic        osc_run_enable,
   input wire logic        osc_low_power,
   input wire logic        sys_clk_from_osc,
   input wire logic [1:0]  power_state
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire wr  = psel && penable && pwrite;
   wire rd  = psel && penable && !pwrite;
   wire sec = power_state == TMR_PWR_SEC_RUN;
   AST_IRQ_HOLD: assert property ($fell(irq) && $past(rst_b) |->
      $past(wr && (paddr == 12'h00C || paddr == 12'h010)))
      else $error("irq fell without a flag or enable write");
   AST_IRQ_MASK: assert property (wr && paddr == 12'h010 &&
      !pwdata[0] |=> !irq) else $error("irq high while masked");
   AST_IRQ_FLAG: assert property (rd && paddr == 12'h00C && irq
      |-> prdata[0]) else $error("irq high with flag clear");
   AST_RUN_FLAG: assert property ($rose(sys_clk_from_osc) |->
      $past(osc_run_enable) && sec)
      else $error("clock source flag rose without oscillator");
   AST_CTRL_RUN: assert property (rd && paddr == 12'h000 |->
      prdata[6] == sys_clk_from_osc) else $error("status bit wrong");
   AST_FAILOVER: assert property (osc_fail && sys_clk_from_osc
      |-> ##[1:3] !sys_clk_from_osc) else $error("no switchover");
   AST_SEC_RUN: assert property (wr && paddr == 12'h014 &&
      pwdata[1:0] == 2'h1 && osc_run_enable && !osc_fail &&
      power_state == TMR_PWR_RUN |=> ##1 sec) else $error("no sec run");
   AST_IDLE: assert property (sec && sleep_exec && !osc_fail &&
      !wr |=> power_state inside {TMR_PWR_SEC_IDLE, TMR_PWR_SLEEP})
      else $error("sleep from sec run went wrong");
   AST_LOWPWR: assert property (wr && paddr == 12'h018 |=>
      osc_low_power == $past(pwdata[0])) else $error("low power bad");
   cover property (sec ##1 power_state == TMR_PWR_SEC_IDLE);
   cover property ($rose(irq));
   cover property (psel && penable && pslverr);
endmodule
bind tmr_timer16 tmr_chk u_chk (
   .mclk             (mclk),
   .rst_b            (rst_b),
   .psel             (psel),
   .penable          (penable),
   .pwrite           (pwrite),
   .paddr            (paddr),
   .pwdata           (pwdata),
   .prdata           (prdata),
   .pslverr          (pslverr),
   .sleep_exec       (sleep_exec),
   .osc_fail         (osc_fail),
   .irq              (irq),
   .osc_run_enable   (osc_run_enable),
   .osc_low_power    (osc_low_power),
   .sys_clk_from_osc (sys_clk_from_osc),
   .power_state      (power_state)
);

// file: tb/tmr_far_model.sv
// crystal and compare trigger outside the timer
`timescale 1ns/1ps
module tmr_far_model
(
   input  wire logic mclk,
   input  wire logic osc_on,
   input  wire logic fire,
   output logic      ext_clk_pin,
   output logic      cmp_trigger
);
   int ph = 0;
   initial begin
      ext_clk_pin = 1'b0;
      cmp_trigger = 1'b0;
   end
   // crystal runs whenever enabled, period 20 mclk
   always @(posedge mclk) begin
      ph <= osc_on ? (ph + 1) % 10 : 0;
      if (osc_on && ph == 9) ext_clk_pin <= !ext_clk_pin;
      cmp_trigger <= fire;
   end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_top;
   import tmr_pkg::*;
   logic        mclk, rst_b, psel, penable, pwrite, fire, sleep_exec;
   logic        wake_event, osc_fail, pready, pslverr, err, irq;
   logic        osc_run_enable, osc_low_power, sys_clk_from_osc;
   logic        ext_clk_pin, cmp_trigger;
   logic [1:0]  power_state;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata, v, n;
   int          n_errors, comparisons, cyc, seed, e;
   tmr_timer16 u_dut (
      .mclk             (mclk),
      .rst_b            (rst_b),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .ext_clk_pin      (ext_clk_pin),
      .cmp_trigger      (cmp_trigger),
      .sleep_exec       (sleep_exec),
      .wake_event       (wake_event),
      .osc_fail         (osc_fail),
      .irq              (irq),
      .osc_run_enable   (osc_run_enable),
      .osc_low_power    (osc_low_power),
      .sys_clk_from_osc (sys_clk_from_osc),
      .power_state      (power_state)
   );
   tmr_far_model u_far (.mclk, .osc_on(osc_run_enable), .fire,
      .ext_clk_pin, .cmp_trigger);
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic apb(input logic w, input int a, input int d, input logic f = 0);
      psel <= 1; pwrite <= w; paddr <= a[11:0]; pwdata <= d; fire <= f;
      @(posedge mclk);
      penable <= 1; fire <= 0;
      do @(posedge mclk); while (pready !== 1'b1);
      rdata = prdata; err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge mclk);
   endtask
   // internal ticks seen in a window: one per four clocks, then prescale
   function automatic int ticks(input int cycles, input int p);
      return cycles / (4 << p);
   endfunction
   task automatic test_done;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin n_errors++; test_done; end
   end
   initial begin
      {psel, penable, pwrite, fire, sleep_exec, wake_event, osc_fail} = 0;
      paddr = 0; pwdata = 0; rst_b = 0; seed = 32'h9F53;
      repeat (2) @(posedge mclk);
      rst_b <= 1;
      @(posedge mclk);
      for (int a = 0; a <= 'h30; a += 4) begin
         apb(0, a, 0);
         `CHK(rdata, 32'h0)
         `CHK(err, a > 'h20)
      end
      repeat (4) begin
         v = $random(seed);
         apb(1, 'h020, v); apb(0, 'h020, 0);
         `CHK(rdata[3:0], v[3:0])
         apb(1, 'h018, v); `CHK(osc_low_power, v[0])
      end
      // wrap near the top of the count, flag masked at first
      apb(1, 'h008, 'hFF); apb(1, 'h004, 'hFE); apb(1, 'h000, 'h01);
      do apb(0, 'h00C, 0); while (rdata[0] !== 1'b1);
      `CHK(irq, 1'b0)
      apb(0, 'h008, 0); `CHK(rdata[7:0], 8'h00)
      apb(1, 'h010, 1); `CHK(irq, 1'b1)
      apb(0, 'h00C, 0); `CHK(rdata[0], 1'b1)
      apb(1, 'h010, 0); `CHK(irq, 1'b0)
      apb(1, 'h00C, 1); apb(1, 'h010, 1); `CHK(irq, 1'b0)
      apb(1, 'h000, 0); apb(0, 'h004, 0); v = rdata;
      repeat (40) @(posedge mclk);
      apb(0, 'h004, 0); `CHK(rdata, v)
      for (int p = 0; p < 4; p++) begin
         apb(1, 'h000, 1 | p << 4); apb(1, 'h008, 0); apb(1, 'h004, 0);
         repeat (256) @(posedge mclk);
         apb(0, 'h004, 0); n = rdata; e = ticks(259, p);
         `CHK(n >= e - 1 && n <= e + 1, 1'b1)
      end
      // trigger alone, trigger against a high write, wrong mode
      apb(1, 'h000, 'h31); apb(1, 'h020, 'hB); apb(1, 'h008, 'h12);
      apb(0, 'h000, 0, 1); apb(0, 'h008, 0); `CHK(rdata, 32'h0)
      apb(0, 'h00C, 0); `CHK(rdata[0], 1'b0)
      apb(1, 'h008, 'h55, 1); apb(0, 'h008, 0); `CHK(rdata, 32'h55)
      apb(1, 'h020, 'hA); apb(0, 'h000, 0, 1);
      apb(0, 'h008, 0); `CHK(rdata, 32'h55)
      apb(1, 'h000, 'h80); apb(1, 'h008, 'hA5); apb(1, 'h004, 'h3C);
      apb(1, 'h000, 'h00); apb(0, 'h008, 0); `CHK(rdata, 32'hA5)
      // second timebase: low byte left alone, high msb set on overflow
      apb(1, 'h008, 'hFF); apb(1, 'h000, 'h01);
      do apb(0, 'h00C, 0); while (rdata[0] !== 1'b1);
      apb(1, 'h008, 'h80); apb(1, 'h00C, 1);
      apb(0, 'h008, 0); `CHK(rdata, 32'h80)
      apb(1, 'h008, 0); apb(1, 'h004, 0); apb(1, 'h000, 'h0B);
      `CHK(osc_run_enable, 1'b1)
      repeat (400) @(posedge mclk);
      apb(0, 'h004, 0); n = rdata;
      `CHK(n >= 18 && n <= 22, 1'b1)
      apb(1, 'h014, 1); @(posedge mclk);
      `CHK(power_state, TMR_PWR_SEC_RUN)
      apb(0, 'h000, 0); `CHK(rdata[6], 1'b1)
      sleep_exec <= 1; @(posedge mclk); sleep_exec <= 0; @(posedge mclk);
      `CHK(power_state, TMR_PWR_SEC_IDLE)
      wake_event <= 1; @(posedge mclk); wake_event <= 0; @(posedge mclk);
      osc_fail <= 1; repeat (4) @(posedge mclk);
      `CHK(sys_clk_from_osc, 1'b0)
      apb(0, 'h000, 0); `CHK(rdata[6], 1'b0)
      test_done;
   end
endmodule
